/* File: alr_div.sv */
// analog level ramp: unsigned restoring divider, one quotient bit per cycle
// assumes go is held only while idle is wanted; a go while busy is ignored
`timescale 1ns/10ps
module alr_div
  import alr_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset
  alr_div_if.slave div // request and answer
);

  typedef struct packed {
    logic run;
    logic [4:0] cnt;
    logic [DVD_W-1:0] q;
    logic [DVS_W:0] rem;
    logic [DVS_W-1:0] dvs;
    logic done;
  } alr_div_st_type;

  alr_div_st_type q_r;
  alr_div_st_type q_nxt;
  logic [DVS_W:0] r2;

  // ==========================================================
  // next state: shift in one dividend bit, subtract when it fits
  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    r2 = {q_r.rem[DVS_W-1:0], q_r.q[DVD_W-1]};
    if (!q_r.run) begin
      if (div.go) begin
        q_nxt.run = 1'b1;
        q_nxt.cnt = 5'(DVD_W - 1);
        q_nxt.q = div.dvd;
        q_nxt.rem = '0;
        q_nxt.dvs = div.dvs;
      end
    end else begin
      if (r2 >= {1'b0, q_r.dvs}) begin
        q_nxt.rem = r2 - {1'b0, q_r.dvs};
        q_nxt.q = {q_r.q[DVD_W-2:0], 1'b1};
      end else begin
        q_nxt.rem = r2;
        q_nxt.q = {q_r.q[DVD_W-2:0], 1'b0};
      end
      q_nxt.cnt = q_r.cnt - 5'h01;
      if (q_r.cnt == 5'h00) begin
        q_nxt.run = 1'b0;
        q_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign div.done = q_r.done;
  assign div.quo = q_r.q;

endmodule

/* File: alr_div_if.sv */
// analog level ramp: request and answer wires of the scaling divider
// assumes both ends run on clk_sys
`timescale 1ns/10ps
interface alr_div_if;
  import alr_pkg::*;
  logic go;
  logic [DVD_W-1:0] dvd;
  logic [DVS_W-1:0] dvs;
  logic done;
  logic [DVD_W-1:0] quo;
  modport master (output go, output dvd, output dvs, input done, input quo);
  modport slave (input go, input dvd, input dvs, output done, output quo);
endinterface

/* File: alr_peer.sv */
// analog level ramp: model of the neighbouring blocks that supply live targets
// assumes one clock shared with the ramp block; values change only on edges
`timescale 1ns/10ps
// ==========================================================
// live target source
module alr_peer (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset, high
  input wire logic [15:0] first_val, // value the bench wants shown
  input wire logic [15:0] second_val, // value the bench wants shown
  output logic [15:0] first_target_ext, // actual value of one block
  output logic [15:0] second_target_ext // actual value of another block
);
  // registered like any block's actual value, so a change lands one cycle late
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_target_ext <= 16'h0000;
      second_target_ext <= 16'h0000;
    end else begin
      first_target_ext <= first_val;
      second_target_ext <= second_val;
    end
  end
endmodule

/* File: alr_pkg.sv */
// analog level ramp: shared constants, register map, state and level types
// assumes one 125 MHz clock; every level value is a signed count in level units
//
// Contract
// - rising enable forces offset plus start/stop offset for 100 ms, then ramps
// - falling enable sets current level to offset at once, output becomes zero
// - level select 0 picks first target, 1 picks second target
// - a select change ramps to the new target at the rate, never jumps
// - rising stop ramps down to start/stop level, holds 100 ms, then offset
// - after a stop request no restart until stop and enable are both low
// - output is level minus offset divided by gain, range 0 to 32767
// - current level is recomputed once every 100 ms update
// - rate is steps per second, 1 to 10000, for every approach
// - both target levels accept -10000 to +20000
// - current level never exceeds the ceiling, range -10000 to +20000
// - start/stop level is offset plus start/stop offset of 0 to +20000
// - gain ranges 0 to 10.00, offset ranges plus or minus 10000
// - the inspection view shows the unscaled current level
// - decimal places 0 to 3 affect display only, never arithmetic
package alr_pkg;

  // ==========================================================
  // register bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_LEVEL1 = 8'h00;
  localparam logic [7:0] OFS_LEVEL2 = 8'h04;
  localparam logic [7:0] OFS_CEIL = 8'h08;
  localparam logic [7:0] OFS_START_STOP_OFFSET = 8'h0C;
  localparam logic [7:0] OFS_RATE = 8'h10;
  localparam logic [7:0] OFS_GAIN = 8'h14;
  localparam logic [7:0] OFS_OFFSET = 8'h18;
  localparam logic [7:0] OFS_DEC = 8'h1C;
  localparam logic [7:0] OFS_SRC = 8'h20;
  localparam logic [7:0] OFS_STATE = 8'h24;
  localparam logic [7:0] OFS_CUR = 8'h28;
  localparam logic [7:0] OFS_SCALED = 8'h2C;

  // ==========================================================
  // value ranges and reset values
  localparam logic signed [15:0] LVL_MIN = -16'sh2710;
  localparam logic signed [15:0] LVL_MAX = 16'sh4E20;
  localparam logic signed [15:0] OFF_MAX = 16'sh2710;
  localparam logic signed [15:0] START_STOP_OFFSET_MAX = 16'sh4E20;
  localparam logic [13:0] RATE_MIN = 14'h0001;
  localparam logic [13:0] RATE_MAX = 14'h2710;
  localparam logic [9:0] GAIN_MAX = 10'h3E8;
  localparam logic [1:0] DEC_MAX = 2'h3;
  localparam logic [9:0] GAIN_RST = 10'h064;
  localparam logic signed [15:0] CEIL_RST = 16'sh4E20;
  localparam logic [13:0] RATE_RST = 14'h0001;

  // ==========================================================
  // arithmetic
  localparam int LVL_W = 18;
  localparam int DVD_W = 24;
  localparam int DVS_W = 10;
  localparam logic [6:0] GAIN_SCALE = 7'h64;
  localparam logic [4:0] STEP_DIV = 5'h0A;
  localparam logic [15:0] OUT_MAX = 16'h7FFF;

  // ==========================================================
  // timing: one level update every 100 ms
  localparam int UPDATE_NS = 100_000_000;
  localparam int CLK_NS = 8;
  localparam int TICK_CYC = UPDATE_NS / CLK_NS;

  typedef logic signed [LVL_W-1:0] alr_lvl_type;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_HOLD_START = 3'h1,
    S_RAMP = 3'h2,
    S_DECEL = 3'h3,
    S_HOLD_STOP = 3'h4,
    S_LATCHED = 3'h5
  } alr_state_type;

endpackage

/* File: alr_top.sv */
// analog level ramp: level state machine, register file and scaled output
// assumes enable, level_sel and decel_stop arrive asynchronously from pins;
// the external target values come from logic on clk_sys
`timescale 1ns/10ps
module alr_top
  import alr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC // cycles per 100 ms update
) (
  input wire logic clk_sys, // 125 MHz clock
  input wire logic rst, // synchronous reset, high
  input wire logic [ADDR_W-1:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic enable, // ramp enable pin
  input wire logic level_sel, // target select pin
  input wire logic decel_stop, // decelerated stop pin
  input wire logic [15:0] first_target_ext, // live value from another block
  input wire logic [15:0] second_target_ext, // live value from another block
  output logic [15:0] scaled_output, // scaled level
  output logic [LVL_W-1:0] current_level // unscaled level for inspection
);

  typedef struct packed {
    alr_state_type st;
    alr_lvl_type cur;
    logic [23:0] tick_cnt;
    logic [3:0] frac;
    logic [2:0] en_s;
    logic [2:0] stp_s;
    logic [1:0] sel_s;
    logic signed [15:0] lvl1;
    logic signed [15:0] lvl2;
    logic signed [15:0] ceil;
    logic signed [15:0] start_stop_offset;
    logic [13:0] rate;
    logic [9:0] gain;
    logic signed [15:0] off;
    logic [1:0] dec;
    logic [1:0] src;
    logic [31:0] rdata;
    logic [15:0] scaled;
    logic div_run;
  } alr_regs_type;

  alr_regs_type q;
  alr_regs_type d;
  alr_div_if div ();

  logic tick;
  logic en_rise;
  logic en_fall;
  logic stp_rise;
  logic [14:0] acc;
  alr_lvl_type step;
  alr_lvl_type tgt;
  alr_lvl_type ss_lvl;
  alr_lvl_type off_l;
  alr_lvl_type nxt_lvl;
  logic signed [LVL_W:0] diff;
  logic signed [15:0] wv;

  function automatic logic signed [15:0] clampv(logic signed [15:0] v,
      logic signed [15:0] lo, logic signed [15:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // move c toward t by at most s, landing exactly on t
  function automatic alr_lvl_type toward(alr_lvl_type c, alr_lvl_type t, alr_lvl_type s);
    if (c < t) begin
      toward = (t - c > s) ? c + s : t;
    end else begin
      toward = (c - t > s) ? c - s : t;
    end
  endfunction

  // ==========================================================
  // derived values for this cycle
  always_comb begin
    tick = (q.tick_cnt == 24'(TICK_CYCLES - 1));
    en_rise = q.en_s[1] & ~q.en_s[2];
    en_fall = ~q.en_s[1] & q.en_s[2];
    stp_rise = q.stp_s[1] & ~q.stp_s[2];
    acc = 15'(q.frac) + 15'(q.rate);
    step = LVL_W'(acc / 15'(STEP_DIV));
    off_l = LVL_W'(q.off);
    ss_lvl = off_l + LVL_W'(q.start_stop_offset);
    // a target may follow another block's live value
    if (q.sel_s[1]) begin
      tgt = q.src[1] ? LVL_W'($signed(second_target_ext)) : LVL_W'(q.lvl2);
    end else begin
      tgt = q.src[0] ? LVL_W'($signed(first_target_ext)) : LVL_W'(q.lvl1);
    end
    diff = (LVL_W + 1)'(q.cur) - (LVL_W + 1)'(off_l);
    wv = wdata[15:0];
  end

  // ==========================================================
  // next state: synchronisers, level machine, registers, divider launch
  always_comb begin
    d = q;
    d.en_s = {q.en_s[1:0], enable};
    d.stp_s = {q.stp_s[1:0], decel_stop};
    d.sel_s = {q.sel_s[0], level_sel};
    d.tick_cnt = tick ? 24'h000000 : q.tick_cnt + 24'h000001;
    if (tick) begin
      d.frac = 4'(acc % 15'(STEP_DIV)); // remainder carries so slow rates stay exact
    end
    nxt_lvl = q.cur;
    case (q.st)
      S_IDLE: begin
        d.cur = off_l;
        if (en_rise && !q.stp_s[1]) begin
          d.st = S_HOLD_START;
          d.cur = ss_lvl;
          d.tick_cnt = 24'h000000;
          d.frac = 4'h0;
        end
      end
      S_HOLD_START: begin
        if (stp_rise) begin
          d.st = S_DECEL;
        end else if (tick) begin
          d.st = S_RAMP;
        end
      end
      S_RAMP: begin
        if (stp_rise) begin
          d.st = S_DECEL;
        end else if (tick) begin
          d.cur = toward(q.cur, tgt, step);
        end
      end
      S_DECEL: begin
        if (tick) begin
          nxt_lvl = toward(q.cur, ss_lvl, step);
          d.cur = nxt_lvl;
          if (nxt_lvl == ss_lvl) begin
            d.st = S_HOLD_STOP;
            d.tick_cnt = 24'h000000; // full 100 ms hold from here
          end
        end
      end
      S_HOLD_STOP: begin
        if (tick) begin
          d.st = S_LATCHED;
          d.cur = off_l;
        end
      end
      S_LATCHED: begin
        d.cur = off_l;
        if (!q.en_s[1] && !q.stp_s[1]) begin
          d.st = S_IDLE;
        end
      end
      default: begin
        d.st = S_IDLE;
        d.cur = off_l;
      end
    endcase
    // enable low wins over every step; a stopped ramp stays latched
    if (en_fall) begin
      d.cur = off_l;
      if (q.st == S_DECEL || q.st == S_HOLD_STOP || q.st == S_LATCHED || q.stp_s[1]) begin
        d.st = S_LATCHED;
      end else begin
        d.st = S_IDLE;
      end
    end
    if (d.cur > LVL_W'(q.ceil)) begin
      d.cur = LVL_W'(q.ceil);
    end
    // register writes clamp to the legal range of each field except decimal places and source, which keep the low two bits
    if (wr) begin
      case (addr)
        OFS_LEVEL1: d.lvl1 = clampv(wv, LVL_MIN, LVL_MAX);
        OFS_LEVEL2: d.lvl2 = clampv(wv, LVL_MIN, LVL_MAX);
        OFS_CEIL: d.ceil = clampv(wv, LVL_MIN, LVL_MAX);
        OFS_START_STOP_OFFSET: d.start_stop_offset = clampv(wv, 16'sh0000, START_STOP_OFFSET_MAX);
        OFS_RATE: d.rate = (wdata[15:0] < 16'(RATE_MIN)) ? RATE_MIN :
            ((wdata[15:0] > 16'(RATE_MAX)) ? RATE_MAX : wdata[13:0]);
        OFS_GAIN: d.gain = (wdata[15:0] > 16'(GAIN_MAX)) ? GAIN_MAX : wdata[9:0];
        OFS_OFFSET: d.off = clampv(wv, -OFF_MAX, OFF_MAX);
        OFS_DEC: d.dec = wdata[1:0];
        OFS_SRC: d.src = wdata[1:0];
        default: begin
        end
      endcase
    end
    // read data stand one cycle; unmapped addresses read zero
    d.rdata = 32'h00000000;
    if (rd) begin
      case (addr)
        OFS_LEVEL1: d.rdata = 32'(q.lvl1);
        OFS_LEVEL2: d.rdata = 32'(q.lvl2);
        OFS_CEIL: d.rdata = 32'(q.ceil);
        OFS_START_STOP_OFFSET: d.rdata = 32'(q.start_stop_offset);
        OFS_RATE: d.rdata = 32'(q.rate);
        OFS_GAIN: d.rdata = 32'(q.gain);
        OFS_OFFSET: d.rdata = 32'(q.off);
        OFS_DEC: d.rdata = 32'(q.dec);
        OFS_SRC: d.rdata = 32'(q.src);
        OFS_STATE: d.rdata = 32'(q.st);
        OFS_CUR: d.rdata = 32'(q.cur);
        OFS_SCALED: d.rdata = 32'(q.scaled);
        default: d.rdata = 32'h00000000;
      endcase
    end
    // divider runs back to back; zero gain gives zero output
    d.div_run = 1'b1;
    if (div.done) begin
      d.div_run = 1'b0;
      if (q.gain == 10'h000) begin
        d.scaled = 16'h0000;
      end else if (div.quo > 24'(OUT_MAX)) begin
        d.scaled = OUT_MAX;
      end else begin
        d.scaled = div.quo[15:0];
      end
    end
  end

  // ==========================================================
  // divider request: (level - offset) * 100 / gain in hundredths
  assign div.go = !q.div_run;
  assign div.dvd = (diff > 0) ? DVD_W'(diff * $signed({1'b0, GAIN_SCALE})) : '0;
  assign div.dvs = (q.gain == 10'h000) ? 10'h001 : q.gain;

  alr_div u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .div(div)
  );

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
      q.st <= S_IDLE;
      q.ceil <= CEIL_RST;
      q.rate <= RATE_RST;
      q.gain <= GAIN_RST;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign scaled_output = q.scaled;
  assign current_level = q.cur;

  // ==========================================================
  // checks
  sequence s_stop_req;
    stp_rise && !en_fall && (q.st == S_HOLD_START || q.st == S_RAMP);
  endsequence

  sequence s_hold_end;
    q.st == S_HOLD_STOP && tick && !en_fall;
  endsequence

  a_en_rise_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (en_rise && q.st == S_IDLE && !q.stp_s[1]) |=> q.st == S_HOLD_START)
    else $error("enable rise did not start the hold");

  a_hold_level_kept: assert property (@(posedge clk_sys) disable iff (rst)
    (q.st == S_HOLD_START && !wr) ##1 (q.st == S_HOLD_START) |-> q.cur == $past(q.cur))
    else $error("start level moved during hold");

  a_en_fall_off: assert property (@(posedge clk_sys) disable iff (rst)
    en_fall |=> (q.cur == $past(off_l) || q.cur == $past(LVL_W'(q.ceil))))
    else $error("enable fall did not drop to offset");

  a_ramp_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (q.st == S_RAMP && !tick && !wr && !stp_rise && !en_fall) |=> q.cur == $past(q.cur))
    else $error("level changed between updates");

  a_stop_decel: assert property (@(posedge clk_sys) disable iff (rst)
    s_stop_req |=> q.st == S_DECEL)
    else $error("stop rise did not start deceleration");

  a_hold_stop_end: assert property (@(posedge clk_sys) disable iff (rst)
    s_hold_end |=> (q.st == S_LATCHED && q.cur <= $past(off_l)))
    else $error("stop hold did not end at offset");

  a_no_restart: assert property (@(posedge clk_sys) disable iff (rst)
    (q.st == S_LATCHED && (q.en_s[1] || q.stp_s[1])) |=> q.st == S_LATCHED)
    else $error("restart before both inputs low");

  a_ceiling_kept: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> q.cur <= $past(LVL_W'(q.ceil)))
    else $error("level above ceiling");

endmodule

/* File: tb_top.sv */
// analog level ramp: self-checking bench over pins, live targets and registers
// assumes alr_top with a short update tick and the peer model as target source
`timescale 1ns/10ps
module tb_top;
  import alr_pkg::*;
  // ==========================================================
  // signals
  localparam int TCK = 40; // cycles per update, long enough for the divider
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic enable = 1'b0;
  logic level_sel = 1'b0;
  logic decel_stop = 1'b0;
  logic [15:0] first_val = 16'h0000;
  logic [15:0] second_val = 16'h0000;
  logic [15:0] first_target_ext;
  logic [15:0] second_target_ext;
  logic [15:0] scaled_output;
  alr_lvl_type current_level;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  // writes beyond each range except decimal places, written at its top value 3, and the value that must read back
  logic [7:0] t_a [7] = '{OFS_RATE, OFS_GAIN, OFS_LEVEL1, OFS_START_STOP_OFFSET, OFS_OFFSET, OFS_CEIL, OFS_DEC};
  logic [31:0] t_w [7] = '{32'h00004E20, 32'h000007D0, 32'hFFFFB1E0, 32'hFFFFFFFB,
    32'h00004E20, 32'h00007530, 32'h00000003};
  logic [31:0] t_e [7] = '{32'h00002710, 32'h000003E8, 32'hFFFFD8F0, 32'h00000000,
    32'h00002710, 32'h00004E20, 32'h00000003};

  // ==========================================================
  // clock, design and far side
  always #4 clk_sys = ~clk_sys;

  alr_top #(.TICK_CYCLES(TCK)) dut_u (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .enable(enable),
    .level_sel(level_sel), .decel_stop(decel_stop), .first_target_ext(first_target_ext),
    .second_target_ext(second_target_ext), .scaled_output(scaled_output),
    .current_level(current_level));

  alr_peer peer_u (.clk_sys(clk_sys), .rst(rst), .first_val(first_val),
    .second_val(second_val), .first_target_ext(first_target_ext),
    .second_target_ext(second_target_ext));

  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe; a gap cycle follows so strobes never collide
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so look just then
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask

  // bounded wait for a level; n keeps the cycles spent for timing checks
  task automatic wait_lvl(input string what, input int exp, input int lim);
    n = 0;
    while (n < lim && current_level != exp) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(what, 32'(exp), 32'(current_level));
  endtask

  task automatic pins(input logic en, input logic st, input logic sel);
    @(posedge clk_sys);
    enable <= en;
    decel_stop <= st;
    level_sel <= sel;
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: the sequence needs about thirty-five updates
  initial begin
    repeat (100 * TCK) @(posedge clk_sys);
    err_total++;
    $display("[FAIL] watchdog expected finish seen timeout");
    test_done();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk("rate reset", OFS_RATE, 32'h00000001);
    rd_chk("gain reset", OFS_GAIN, 32'h00000064);
    rd_chk("ceiling reset", OFS_CEIL, 32'h00004E20);
    rd_chk("state reset", OFS_STATE, 32'h00000000);
    rd_chk("unmapped read", 8'h30, 32'h00000000);
    end_test("reset");
    for (int i = 0; i < 7; i++) begin
      wr_reg(t_a[i], t_w[i]);
      rd_chk("range limit", t_a[i], t_e[i]);
    end
    end_test("ranges");
    // offset 100, start/stop 150, targets 400 and 200, 100 per update, gain 2.00
    wr_reg(OFS_OFFSET, 32'h00000064);
    wr_reg(OFS_START_STOP_OFFSET, 32'h00000032);
    wr_reg(OFS_LEVEL1, 32'h00000190);
    wr_reg(OFS_LEVEL2, 32'h000000C8);
    wr_reg(OFS_RATE, 32'h000003E8);
    wr_reg(OFS_GAIN, 32'h000000C8);
    wr_reg(OFS_CEIL, 32'h00004E20);
    pins(1'b1, 1'b0, 1'b0);
    wait_lvl("start level", 150, 10);
    wait_lvl("first step", 250, 2 * TCK + 10);
    chk("start hold", 32'h1, 32'(n >= TCK));
    wait_lvl("second step", 350, TCK + 2);
    chk("update spacing", 32'(TCK), 32'(n));
    rd_chk("ramp state", OFS_STATE, 32'h00000002);
    wait_lvl("first target", 400, TCK + 4);
    repeat (TCK + 20) @(posedge clk_sys);
    #1;
    chk("no overshoot", 32'h00000190, 32'(current_level));
    chk("scaled", 32'h00000096, 32'(scaled_output));
    rd_chk("scaled reg", OFS_SCALED, 32'h00000096);
    rd_chk("level reg", OFS_CUR, 32'h00000190);
    end_test("start ramp");
    pins(1'b1, 1'b0, 1'b1);
    wait_lvl("select step", 300, TCK + 10);
    wait_lvl("second target", 200, TCK + 4);
    end_test("select");
    wr_reg(OFS_CEIL, 32'h000000FA);
    pins(1'b1, 1'b0, 1'b0);
    wait_lvl("ceiling reach", 250, TCK + 10);
    repeat (2 * TCK) @(posedge clk_sys);
    #1;
    chk("ceiling hold", 32'h000000FA, 32'(current_level));
    wr_reg(OFS_CEIL, 32'h00004E20);
    wait_lvl("ceiling lifted", 400, 3 * TCK);
    end_test("ceiling");
    pins(1'b1, 1'b1, 1'b0);
    wait_lvl("decel step", 300, TCK + 10);
    rd_chk("decel state", OFS_STATE, 32'h00000003);
    wait_lvl("stop level", 150, 2 * TCK + 4);
    wait_lvl("stop drop", 100, TCK + 4);
    chk("stop hold", 32'h1, 32'(n >= TCK - 2));
    rd_chk("latched state", OFS_STATE, 32'h00000005);
    repeat (60) @(posedge clk_sys);
    #1;
    chk("scaled stop", 32'h00000000, 32'(scaled_output));
    pins(1'b1, 1'b0, 1'b0);
    repeat (8) @(posedge clk_sys);
    rd_chk("still latched", OFS_STATE, 32'h00000005);
    pins(1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge clk_sys);
    rd_chk("released", OFS_STATE, 32'h00000000);
    end_test("decel stop");
    // a rise of enable while stop is high must be refused
    pins(1'b1, 1'b1, 1'b0);
    repeat (2 * TCK) @(posedge clk_sys);
    rd_chk("refused state", OFS_STATE, 32'h00000000);
    chk("refused level", 32'h00000064, 32'(current_level));
    pins(1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge clk_sys);
    pins(1'b1, 1'b0, 1'b0);
    wait_lvl("restart", 150, 10);
    wait_lvl("restart step", 250, 2 * TCK + 10);
    pins(1'b0, 1'b0, 1'b0);
    wait_lvl("enable off", 100, 8);
    repeat (60) @(posedge clk_sys);
    #1;
    chk("scaled off", 32'h00000000, 32'(scaled_output));
    rd_chk("off state", OFS_STATE, 32'h00000000);
    end_test("enable off");
    // live targets: 300 on the first, 250 on the second
    first_val <= 16'h012C;
    second_val <= 16'h00FA;
    wr_reg(OFS_SRC, 32'h00000003);
    pins(1'b1, 1'b0, 1'b0);
    wait_lvl("live start", 150, 10);
    wait_lvl("live first", 300, 4 * TCK);
    repeat (60) @(posedge clk_sys);
    #1;
    chk("live scaled", 32'h00000064, 32'(scaled_output));
    pins(1'b1, 1'b0, 1'b1);
    wait_lvl("live second", 250, 2 * TCK);
    repeat (60) @(posedge clk_sys);
    #1;
    chk("live second scaled", 32'h0000004B, 32'(scaled_output));
    // offset far below the level at gain 0.01 pushes the quotient past the top
    wr_reg(OFS_GAIN, 32'h00000001);
    wr_reg(OFS_OFFSET, 32'hFFFFD8F0);
    repeat (60) @(posedge clk_sys);
    #1;
    chk("scaled clamp", 32'h00007FFF, 32'(scaled_output));
    wr_reg(OFS_GAIN, 32'h00000000);
    repeat (60) @(posedge clk_sys);
    #1;
    chk("gain zero", 32'h00000000, 32'(scaled_output));
    end_test("live targets");
    test_done();
  end
endmodule
